/* File: dtme_pkg.sv */
// dtme_pkg: constants and carrier types of the descriptor transfer engine
// assumes nothing; used by dtme_engine and dtme_addr_step
package dtme_pkg;
  // register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_ENA  = 12'h004;
  localparam logic [11:0] REG_BASE = 12'h008;
  localparam logic [11:0] REG_STAT = 12'h00c;
  // bit positions
  localparam int CTRL_REPEAT_CHAIN_ENABLE_BIT = 0;
  localparam int CTRL_FULL_BIT  = 1;
  localparam int ENA_BIT        = 0;
  localparam int MA_SM_LSB      = 6;
  localparam int MA_MD_LSB      = 4;
  localparam int MA_SZ_LSB      = 2;
  localparam int MB_CHAIN_ENABLE_BIT    = 7;
  localparam int MB_CHAIN_ON_ZERO_BIT    = 6;
  localparam int MB_PER_TRANSFER_IRQ_SELECT_BIT   = 5;
  localparam int MB_DTS_BIT     = 4;
  localparam int MB_DM_LSB      = 2;
  // reset values
  localparam logic [31:0] BASE_RST = 32'h0000_0000;
  // descriptor layout
  localparam logic [1:0] LAST_FULL  = 2'h3;
  localparam logic [1:0] LAST_SHORT = 2'h2;
  localparam logic [1:0] WB_COUNTS  = 2'h2;
  localparam logic [31:0] LEN_FULL  = 32'h0000_0010;
  localparam logic [31:0] LEN_SHORT = 32'h0000_000c;
  localparam logic [1:0] SZ_LONG    = 2'h2;

  typedef enum logic [1:0] {
    MD_NORMAL = 2'h0,
    MD_REPEAT = 2'h1,
    MD_BLOCK  = 2'h2
  } dtme_md_type;

  // high bit 0 means fixed
  localparam logic [1:0] AM_INC = 2'h2;
  localparam logic [1:0] AM_DEC = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_INFO = 3'h1,
    ST_DRD  = 3'h3,
    ST_DWR  = 3'h2,
    ST_WB   = 3'h6
  } dtme_st_type;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dtme_mreq_type;

  typedef struct packed {
    dtme_st_type   st;
    logic [1:0]    idx;
    logic [31:0]   desc;
    logic [31:0]   base;
    logic [7:0]    ma;
    logic [7:0]    mb;
    logic [31:0]   source_address_reg;
    logic [31:0]   destination_address_reg;
    logic [15:0]   main_transfer_count;
    logic [15:0]   block_transfer_count;
    logic [31:0]   data;
    logic          reload;
    dtme_mreq_type mreq;
    logic          irq;
    logic          fclr;
    logic          ena;
    logic          repeat_chain_enable;
    logic          full;
    logic [31:0]   prdata;
    logic          perr;
  } dtme_state_type;
endpackage

/* File: dtme_addr_step.sv */
// dtme_addr_step: next address and area-restore address of one pointer
// assumes mode high bit 0 is fixed, size 0/1/2 is byte/word/longword
`timescale 1ns/10ps
module dtme_addr_step (
  input  wire logic [31:0] addr,
  input  wire logic [1:0]  mode,
  input  wire logic [1:0]  size,
  input  wire logic [7:0]  back_cnt,
  output logic      [31:0] next,
  output logic      [31:0] back
);
  logic [31:0] step;
  logic [31:0] span;

  always_comb begin
    step = 32'h0000_0001 << size;
    span = {24'h00_0000, back_cnt} << size;
    next = addr;
    back = addr;
    if (mode == dtme_pkg::AM_INC) begin
      next = addr + step;
      back = addr - span;
    end else if (mode == dtme_pkg::AM_DEC) begin
      next = addr - step;
      back = addr + span;
    end
  end
endmodule // dtme_addr_step

/* File: dtme_engine.sv */
// dtme_engine: descriptor driven transfer engine with apb registers
// assumes one pclk domain; memory slave answers with mem_ack while
// mem_o.req is high; act_req comes from logic on pclk
//
// Notes on behaviour
// - source writeback skipped when source mode high bit 0; same for dest
// - writeback skip acts alike in short and full descriptor format
// - both count fields are always written back
// - full format never writes back the two mode fields
// - normal mode moves one unit, main count minus one, count B kept
// - source and destination step independently per own mode
// - normal mode may raise cpu interrupt when count completes
// - repeat mode moves one unit; area select picks repeat side
// - repeat end restores counter and repeat-area address, continues
// - repeat low count reloads from high byte, zero only if the high byte is zero
// - select 0 restores destination, select 1 restores source
// - block mode moves a whole block per activation
// - block size 1 to 256, held high byte, counted in low byte
// - after block restore counter and block-area address
// - block counter minus one per block; interrupt when done
// - chain enable runs next descriptor on same activation
// - chain plus chain-on-zero chains only at zero count in normal and block mode
// - each chained descriptor has its own fields
// - chained descriptor: no interrupt, flag and enable untouched
// - repeat with repeat-chain enable chains after count-1 transfer
// - separate source and destination address registers
`timescale 1ns/10ps
module dtme_engine #(
  parameter int APB_AW = 12
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [APB_AW-1:0]      paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   act_req,
  output dtme_pkg::dtme_mreq_type     mem_o,
  input  wire logic                   mem_ack,
  input  wire logic [31:0]            mem_rdata,
  output logic                        cpu_irq,
  output logic                        src_flag_clr
);
  if (APB_AW < 4) begin : g_chk
    $error("APB_AW too small for register map");
  end

  dtme_pkg::dtme_state_type s_q, s_d;
  dtme_pkg::dtme_md_type    md;
  logic [1:0]  sm, dm, sz, woff;
  logic [7:0]  count_reload_byte, count_low_byte, backc;
  logic        chain_enable, chain_on_zero, per_transfer_irq_select, area_side_select, hit, cnt_zero, chz;
  logic [11:0] ra;
  logic [31:0] s_next, s_back, d_next, d_back;

  assign md    = dtme_pkg::dtme_md_type'(s_q.ma[dtme_pkg::MA_MD_LSB +: 2]);
  assign sm    = s_q.ma[dtme_pkg::MA_SM_LSB +: 2];
  assign sz    = s_q.ma[dtme_pkg::MA_SZ_LSB +: 2];
  assign dm    = s_q.mb[dtme_pkg::MB_DM_LSB +: 2];
  assign chain_enable  = s_q.mb[dtme_pkg::MB_CHAIN_ENABLE_BIT];
  assign chain_on_zero  = s_q.mb[dtme_pkg::MB_CHAIN_ON_ZERO_BIT];
  assign per_transfer_irq_select = s_q.mb[dtme_pkg::MB_PER_TRANSFER_IRQ_SELECT_BIT];
  assign area_side_select   = s_q.mb[dtme_pkg::MB_DTS_BIT];
  assign count_reload_byte  = s_q.main_transfer_count[15:8];
  assign count_low_byte  = s_q.main_transfer_count[7:0];
  assign backc = count_reload_byte - 8'h01;
  assign ra    = {{(12 - 4){1'b0}}, paddr[3:0]};
  assign hit   = (paddr[APB_AW-1:4] == '0) && (paddr[1:0] == 2'h0);

  dtme_addr_step u_src_step (
    .addr     (s_q.source_address_reg),
    .mode     (sm),
    .size     (sz),
    .back_cnt (backc),
    .next     (s_next),
    .back     (s_back)
  );

  dtme_addr_step u_dst_step (
    .addr     (s_q.destination_address_reg),
    .mode     (dm),
    .size     (sz),
    .back_cnt (backc),
    .next     (d_next),
    .back     (d_back)
  );

  always_comb begin
    s_d      = s_q;
    s_d.irq  = 1'b0;
    s_d.fclr = 1'b0;
    woff     = 2'h0;
    cnt_zero = ((md == dtme_pkg::MD_NORMAL) && (s_q.main_transfer_count == 16'h0000)) ||
               ((md == dtme_pkg::MD_BLOCK) && (s_q.block_transfer_count == 16'h0000));
    chz      = (md == dtme_pkg::MD_REPEAT) ? (s_q.repeat_chain_enable & s_q.reload)
                                           : cnt_zero;
    // apb: read data captured in setup, write in access
    if (psel && !penable) begin
      s_d.perr   = !hit;
      s_d.prdata = 32'h0000_0000;
      case (ra)
        dtme_pkg::REG_CTRL: begin
          s_d.prdata[dtme_pkg::CTRL_REPEAT_CHAIN_ENABLE_BIT] = s_q.repeat_chain_enable;
          s_d.prdata[dtme_pkg::CTRL_FULL_BIT]  = s_q.full;
        end
        dtme_pkg::REG_ENA:  s_d.prdata[dtme_pkg::ENA_BIT] = s_q.ena;
        dtme_pkg::REG_BASE: s_d.prdata = s_q.base;
        dtme_pkg::REG_STAT: s_d.prdata = {29'h0, s_q.st};
        default:            s_d.prdata = 32'h0000_0000;
      endcase
    end
    if (psel && penable && pwrite && hit) begin
      case (ra)
        dtme_pkg::REG_CTRL: begin
          s_d.repeat_chain_enable = pwdata[dtme_pkg::CTRL_REPEAT_CHAIN_ENABLE_BIT];
          s_d.full  = pwdata[dtme_pkg::CTRL_FULL_BIT];
        end
        dtme_pkg::REG_ENA:  s_d.ena  = pwdata[dtme_pkg::ENA_BIT];
        dtme_pkg::REG_BASE: s_d.base = pwdata;
        default: ;
      endcase
    end
    // engine
    case (s_q.st)
      dtme_pkg::ST_IDLE: begin
        if (act_req && s_q.ena) begin
          s_d.st   = dtme_pkg::ST_INFO;
          s_d.desc = s_q.base;
          s_d.idx  = 2'h0;
        end
      end
      dtme_pkg::ST_INFO: begin
        if (mem_ack) begin
          // each descriptor loads all of its own fields
          if (s_q.full) begin
            case (s_q.idx)
              2'h0: begin
                s_d.ma = mem_rdata[31:24];
                s_d.mb = mem_rdata[23:16];
              end
              2'h1: s_d.source_address_reg = mem_rdata;
              2'h2: s_d.destination_address_reg = mem_rdata;
              default: {s_d.main_transfer_count, s_d.block_transfer_count} = mem_rdata;
            endcase
          end else begin
            case (s_q.idx)
              2'h0: {s_d.ma, s_d.source_address_reg} = {mem_rdata[31:24], 8'h00,
                                         mem_rdata[23:0]};
              2'h1: {s_d.mb, s_d.destination_address_reg} = {mem_rdata[31:24], 8'h00,
                                         mem_rdata[23:0]};
              default: {s_d.main_transfer_count, s_d.block_transfer_count} = mem_rdata;
            endcase
          end
          if (s_q.idx == (s_q.full ? dtme_pkg::LAST_FULL
                                   : dtme_pkg::LAST_SHORT)) begin
            s_d.st  = dtme_pkg::ST_DRD;
            s_d.idx = 2'h0;
          end else begin
            s_d.idx = s_q.idx + 2'h1;
          end
        end
      end
      dtme_pkg::ST_DRD: begin
        if (mem_ack) begin
          s_d.data = mem_rdata;
          s_d.st   = dtme_pkg::ST_DWR;
        end
      end
      dtme_pkg::ST_DWR: begin
        if (mem_ack) begin
          s_d.source_address_reg    = s_next;
          s_d.destination_address_reg    = d_next;
          s_d.reload = 1'b0;
          s_d.st     = dtme_pkg::ST_WB;
          case (md)
            dtme_pkg::MD_NORMAL: s_d.main_transfer_count = s_q.main_transfer_count - 16'h0001;
            dtme_pkg::MD_REPEAT: begin
              if (count_low_byte == 8'h01) begin
                s_d.main_transfer_count[7:0] = count_reload_byte;
                s_d.reload   = 1'b1;
                if (area_side_select) s_d.source_address_reg = s_back;
                else     s_d.destination_address_reg = d_back;
              end else begin
                s_d.main_transfer_count[7:0] = count_low_byte - 8'h01;
              end
            end
            default: begin
              // one whole block per activation
              if (count_low_byte == 8'h01) begin
                s_d.main_transfer_count[7:0] = count_reload_byte;
                s_d.block_transfer_count      = s_q.block_transfer_count - 16'h0001;
                if (area_side_select) s_d.source_address_reg = s_back;
                else     s_d.destination_address_reg = d_back;
              end else begin
                s_d.main_transfer_count[7:0] = count_low_byte - 8'h01;
                s_d.st       = dtme_pkg::ST_DRD;
              end
            end
          endcase
        end
      end
      dtme_pkg::ST_WB: begin
        if (mem_ack) begin
          if (s_q.idx == dtme_pkg::WB_COUNTS) begin
            s_d.idx = 2'h0;
            if (chain_enable && (!chain_on_zero || chz)) begin
              s_d.st   = dtme_pkg::ST_INFO;
              s_d.desc = s_q.desc + (s_q.full ? dtme_pkg::LEN_FULL
                                              : dtme_pkg::LEN_SHORT);
            end else begin
              s_d.st = dtme_pkg::ST_IDLE;
              if (!chain_enable) begin
                if (per_transfer_irq_select || cnt_zero) begin
                  s_d.irq = 1'b1;
                  s_d.ena = 1'b0;
                end else begin
                  s_d.fclr = 1'b1;
                end
              end
            end
          end else begin
            s_d.idx = s_q.idx + 2'h1;
          end
        end
      end
      default: s_d.st = dtme_pkg::ST_IDLE;
    endcase
    // request for the next state, rebuilt unchanged while waiting
    s_d.mreq.req   = 1'b1;
    s_d.mreq.we    = 1'b0;
    s_d.mreq.size  = dtme_pkg::SZ_LONG;
    s_d.mreq.wdata = 32'h0000_0000;
    s_d.mreq.addr  = s_d.desc + {28'h000_0000, s_d.idx, 2'h0};
    case (s_d.st)
      dtme_pkg::ST_IDLE: s_d.mreq.req = 1'b0;
      dtme_pkg::ST_INFO: ;
      dtme_pkg::ST_DRD: begin
        s_d.mreq.addr = s_d.source_address_reg;
        s_d.mreq.size = s_d.ma[dtme_pkg::MA_SZ_LSB +: 2];
      end
      dtme_pkg::ST_DWR: begin
        s_d.mreq.we    = 1'b1;
        s_d.mreq.addr  = s_d.destination_address_reg;
        s_d.mreq.size  = s_d.ma[dtme_pkg::MA_SZ_LSB +: 2];
        s_d.mreq.wdata = s_d.data;
      end
      dtme_pkg::ST_WB: begin
        // fixed addresses are not written back, in either format
        if (s_d.idx == 2'h0 && !s_d.ma[dtme_pkg::MA_SM_LSB + 1])
          s_d.idx = 2'h1;
        if (s_d.idx == 2'h1 && !s_d.mb[dtme_pkg::MB_DM_LSB + 1])
          s_d.idx = 2'h2;
        // full format skips word 0, so modes never go back
        woff          = s_d.idx + {1'b0, s_d.full};
        s_d.mreq.we   = 1'b1;
        s_d.mreq.addr = s_d.desc + {28'h000_0000, woff, 2'h0};
        case (s_d.idx)
          2'h0: s_d.mreq.wdata = s_d.full ? s_d.source_address_reg
                                          : {s_d.ma, s_d.source_address_reg[23:0]};
          2'h1: s_d.mreq.wdata = s_d.full ? s_d.destination_address_reg
                                          : {s_d.mb, s_d.destination_address_reg[23:0]};
          default: s_d.mreq.wdata = {s_d.main_transfer_count, s_d.block_transfer_count};
        endcase
      end
      default: s_d.mreq.req = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q      <= '0;
      s_q.st   <= dtme_pkg::ST_IDLE;
      s_q.base <= dtme_pkg::BASE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata       = s_q.prdata;
  assign pready       = 1'b1;
  assign pslverr      = s_q.perr;
  assign mem_o        = s_q.mreq;
  assign cpu_irq      = s_q.irq;
  assign src_flag_clr = s_q.fclr;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_irq_no_chain: assert property (
    (s_q.irq || s_q.fclr) |-> !chain_enable)
    else $error("end action on chained descriptor");
  a_irq_ena_clear: assert property (
    s_q.irq |-> !s_q.ena && !s_q.fclr && $past(s_q.st) == dtme_pkg::ST_WB)
    else $error("interrupt without enable clear");
  a_rpt_no_zero: assert property (
    (s_q.st == dtme_pkg::ST_WB && md == dtme_pkg::MD_REPEAT)
      |-> count_low_byte != 8'h00 || count_reload_byte == 8'h00)
    else $error("repeat counter reached zero");
  a_wb_src_skip: assert property (
    (s_q.st == dtme_pkg::ST_WB && s_q.mreq.req && s_q.idx == 2'h0)
      |-> sm[1])
    else $error("fixed source written back");
  a_wb_dst_skip: assert property (
    (s_q.st == dtme_pkg::ST_WB && s_q.mreq.req && s_q.idx == 2'h1)
      |-> dm[1])
    else $error("fixed destination written back");
  a_wb_no_mode: assert property (
    (s_q.st == dtme_pkg::ST_WB && s_q.full)
      |-> s_q.mreq.addr != s_q.desc)
    else $error("mode word written back in full format");
  a_norm_count: assert property (
    (s_q.st == dtme_pkg::ST_DWR && mem_ack && md == dtme_pkg::MD_NORMAL)
      |=> s_q.main_transfer_count == $past(s_q.main_transfer_count) - 16'h0001 &&
          s_q.block_transfer_count == $past(s_q.block_transfer_count) && s_q.st == dtme_pkg::ST_WB)
    else $error("normal count not decremented");
  a_info_order: assert property (
    (s_q.st == dtme_pkg::ST_INFO && $past(s_q.st) != dtme_pkg::ST_INFO)
      |-> $past(s_q.st) == dtme_pkg::ST_IDLE ||
          $past(s_q.st) == dtme_pkg::ST_WB)
    else $error("descriptor read before writeback");
  a_blk_restore: assert property (
    (s_q.st == dtme_pkg::ST_DWR && mem_ack && md == dtme_pkg::MD_BLOCK &&
     count_low_byte == 8'h01)
      |=> s_q.main_transfer_count[7:0] == $past(count_reload_byte) &&
          s_q.block_transfer_count == $past(s_q.block_transfer_count) - 16'h0001)
    else $error("block end not restored");
  a_chain_next: assert property (
    (s_q.st == dtme_pkg::ST_WB && mem_ack && chain_enable && !chain_on_zero &&
     s_q.idx == dtme_pkg::WB_COUNTS)
      |=> s_q.st == dtme_pkg::ST_INFO && s_q.idx == 2'h0)
    else $error("chained descriptor not fetched");
  a_norm_step: assert property (
    (s_q.st == dtme_pkg::ST_DWR && mem_ack && md == dtme_pkg::MD_NORMAL &&
     sm == dtme_pkg::AM_INC)
      |=> s_q.source_address_reg == $past(s_q.source_address_reg) + (32'h0000_0001 << $past(sz)))
    else $error("source step not by data size");
  a_clr_after_wb: assert property (
    s_q.fclr |-> !s_q.irq && $past(s_q.st) == dtme_pkg::ST_WB)
    else $error("flag clear outside descriptor end");
endmodule // dtme_engine

/* File: dtme_mem_model.sv */
// dtme_mem_model: byte memory slave on the engine's master port
// assumes mem_o held until acked; slow adds three wait cycles
`timescale 1ns/10ps
module dtme_mem_model (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire dtme_pkg::dtme_mreq_type mem_o,
  input  wire logic                    slow,
  output logic                         mem_ack,
  output logic                  [31:0] mem_rdata
);
  logic [7:0] mem [0:255];
  int         wcnt [0:63];
  int         wait_n;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      wait_n <= 0;
    end else if (mem_o.req && mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_n <= 0;
      if (mem_o.we) begin
        wcnt[mem_o.addr[7:2]]++;
        for (int i = 0; i < (1 << mem_o.size); i++)
          mem[8'(mem_o.addr[7:0] + i)] = mem_o.wdata[8*i +: 8];
      end
    end else if (mem_o.req && wait_n >= (slow ? 3 : 0)) begin
      mem_ack <= 1'b1;
      for (int i = 0; i < 4; i++)
        mem_rdata[8*i +: 8] <= mem[8'(mem_o.addr[7:0] + i)];
    end else begin
      // data lines toggle while nothing is answered
      mem_rdata <= ~mem_rdata;
      wait_n <= mem_o.req ? wait_n + 1 : 0;
    end
  end
endmodule // dtme_mem_model

/* File: dtme_engine_tb.sv */
// dtme_engine_tb: apb and activation driven checks of dtme_engine
// assumes dtme_mem_model as the memory on the master port
`timescale 1ns/10ps
`define MM i_dtme_mem_model
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
  fail_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module dtme_engine_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0;
  logic        pwrite = 0, act_req = 0, slow = 0, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, mem_rdata;
  logic        pready, pslverr, mem_ack, cpu_irq, src_flag_clr;
  dtme_pkg::dtme_mreq_type mem_o;
  int          fail_count = 0, n_compared = 0, n_irq, n_clr;

  dtme_engine #(.APB_AW(12)) i_dtme_engine (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .act_req(act_req), .mem_o(mem_o), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .cpu_irq(cpu_irq),
    .src_flag_clr(src_flag_clr));
  dtme_mem_model i_dtme_mem_model (.pclk(pclk), .presetn(presetn),
    .mem_o(mem_o), .slow(slow), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  always #2 pclk = ~pclk;

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic put32(input int a, input logic [31:0] v);
    for (int i = 0; i < 4; i++) `MM.mem[a+i] = v[8*i +: 8];
  endtask

  function automatic logic [31:0] get32(input int a);
    return {`MM.mem[a+3], `MM.mem[a+2], `MM.mem[a+1], `MM.mem[a]};
  endfunction

  task automatic sdesc(input int a, input logic [7:0] ma, mb,
                       input logic [23:0] s, d, input logic [31:0] c);
    put32(a, {ma, s});
    put32(a + 4, {mb, d});
    put32(a + 8, c);
  endtask

  task automatic fill;
    for (int i = 0; i < 256; i++) `MM.mem[i] = 8'(i);
  endtask

  // one activation; ends after 20 quiet cycles on the master port
  task automatic act;
    int   idle;
    logic seen;
    idle = 0;
    seen = 1'b0;
    n_irq = 0;
    n_clr = 0;
    for (int i = 0; i < 64; i++) `MM.wcnt[i] = 0;
    apb(1'b1, 12'h004, 32'h1);
    act_req <= 1'b1;
    while (idle < 20) begin
      // outputs looked at mid-cycle, where they are settled
      @(negedge pclk);
      seen = seen || (mem_o.req === 1'b1);
      idle = (mem_o.req === 1'b1 || act_req) ? 0 : idle + 1;
      n_irq += (cpu_irq === 1'b1);
      n_clr += (src_flag_clr === 1'b1);
      @(posedge pclk);
      if (seen) act_req <= 1'b0;
    end
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    #20000;
    fail_count++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      `CHK(rd, 32'h0)
      `CHK(err, 1'b0)
    end
    `CHK(pready, 1'b1)
    apb(1'b0, 12'h010, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, 12'h00a, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, 12'h008, 32'h40);
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rd, 32'h40)
    fill();
    sdesc(64, 8'h00, 8'h08, 24'h80, 24'ha0, 32'h0002_1234);
    act();
    `CHK(`MM.mem[160], 8'h80)
    `CHK(`MM.wcnt[16], 0)
    `CHK(get32(68), 32'h0800_00a1)
    `CHK(get32(72), 32'h0001_1234)
    `CHK(n_clr, 1)
    act();
    `CHK(get32(72), 32'h0000_1234)
    `CHK(get32(68), 32'h0800_00a2)
    `CHK(n_irq, 1)
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b1, 12'h000, 32'h2);
    slow <= 1'b1;
    put32(64, 32'h880c_0000);
    put32(68, 32'h80);
    put32(72, 32'hc0);
    put32(76, 32'h0005_0007);
    put32(128, 32'h1122_3344);
    act();
    slow <= 1'b0;
    `CHK(get32(192), 32'h1122_3344)
    `CHK(`MM.wcnt[16], 0)
    `CHK(get32(68), 32'h84)
    `CHK(get32(72), 32'hbc)
    `CHK(get32(76), 32'h0004_0007)
    apb(1'b1, 12'h000, 32'h0);
    fill();
    sdesc(64, 8'h94, 8'h08, 24'h80, 24'ha0, 32'h0202_0000);
    act();
    `CHK(get32(72), 32'h0201_0000)
    act();
    `CHK({`MM.mem[163], `MM.mem[162]}, 16'h8382)
    `CHK(get32(68), 32'h0800_00a0)
    `CHK(get32(64), 32'h9400_0084)
    `CHK(get32(72), 32'h0202_0000)
    `CHK(n_irq, 0)
    fill();
    sdesc(64, 8'ha0, 8'h18, 24'h80, 24'hc0, 32'h0202_0001);
    act();
    `CHK({`MM.mem[193], `MM.mem[192]}, 16'h8180)
    `CHK(get32(64), 32'ha000_0080)
    `CHK(get32(68), 32'h1800_00c2)
    `CHK(get32(72), 32'h0202_0000)
    `CHK(n_irq, 1)
    sdesc(64, 8'h00, 8'h80, 24'h80, 24'hd0, 32'h0005_0000);
    sdesc(76, 8'h00, 8'h08, 24'h81, 24'he0, 32'h0003_0000);
    act();
    `CHK(`MM.mem[208], 8'h80)
    `CHK(`MM.mem[224], 8'h81)
    `CHK(get32(72), 32'h0004_0000)
    `CHK(get32(84), 32'h0002_0000)
    `CHK(`MM.wcnt[16] + `MM.wcnt[17], 0)
    `CHK(n_irq, 0)
    `CHK(n_clr, 1)
    put32(68, 32'hc000_00d0);
    act();
    `CHK(get32(72), 32'h0003_0000)
    `CHK(get32(84), 32'h0002_0000)
    `CHK(n_irq + n_clr, 0)
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd, 32'h1)
    apb(1'b1, 12'h000, 32'h1);
    sdesc(64, 8'h90, 8'hc8, 24'h80, 24'hd0, 32'h0101_0000);
    act();
    `CHK(get32(84), 32'h0001_0000)
    `CHK(get32(72), 32'h0101_0000)
    sdesc(64, 8'hc0, 8'h20, 24'h90, 24'hf0, 32'h0003_0000);
    act();
    `CHK(`MM.mem[240], 8'h90)
    `CHK(get32(64), 32'hc000_008f)
    `CHK(`MM.wcnt[17], 0)
    `CHK(get32(72), 32'h0002_0000)
    `CHK(n_irq, 1)
    wrap_up();
  end
endmodule // dtme_engine_tb
